// >>> hw/uart_ctrl_regs.svh
// register offsets, field positions and reset values of the serial control glue
`ifndef UART_CTRL_REGS_SVH
`define UART_CTRL_REGS_SVH
`define OFF_PORT1_LATCH   4'h0
`define OFF_PORT1_DIR     4'h1
`define OFF_IRQ_FLAGS     4'h2
`define OFF_IRQ_MASK      4'h3
`define OFF_CHAN_START    4'h4
`define OFF_CHAN_ENABLED  4'h5
`define OFF_PRIO_HIGH     4'h6
`define OFF_PRIO_LOW      4'h7
`define OFF_CHAN_STOP     4'h8
`define OFF_CHAN_CONFIG   4'h9
`define OFF_IRQ_LEVEL     4'hA
`define BIT_RX_PIN        1
`define BIT_TX_PIN        2
`define BIT_TX_DONE       0
`define BIT_RX_DONE       1
`define BIT_RX_ERROR      2
`define BIT_RX_ENABLE     14
`define RST_PORT1_LATCH   8'hFF
`define RST_PORT1_DIR     8'hFF
`define RST_IRQ_MASK      8'hFF
`define RST_PRIO          8'hFF
`define RX_START_WAIT_CYC 4
`endif

// >>> hw/uart_ctrl_pkg.sv
// types shared by the serial control glue
package uart_ctrl_pkg;
  typedef enum logic [1:0] {
    prio_level0,
    prio_level1,
    prio_level2,
    prio_level3
  } prio_level_t;
  typedef enum logic [1:0] {
    chan_stopped,
    chan_comm_wait
  } chan_state_t;
endpackage

// >>> hw/uart_channel_irq_pin_start_ctrl.sv
// interrupt flags, pin control and channel start triggers of one serial unit
`timescale 1ns/1ns
`default_nettype none
`include "uart_ctrl_regs.svh"
module uart_channel_irq_pin_start_ctrl
  import uart_ctrl_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire logic                  tx_done_event,
  input  wire logic                  rx_done_event,
  input  wire logic                  rx_error_event,
  input  wire logic [7:0]            port1_pin_in,
  output logic      [7:0]            port1_pin_out,
  output logic      [7:0]            port1_pin_oe,
  output logic                       irq,
  output logic      [1:0]            irq_level,
  output logic      [CHANNELS-1:0]   channel_enabled_status,
  output logic      [CHANNELS-1:0]   channel_start_pulse,
  output logic      [CHANNELS-1:0]   receive_enable_bit
);

  // registers
  logic [7:0]          port1_output_latch_r;
  logic [7:0]          port1_direction_r;
  logic [7:0]          irq_request_flags_high_r;
  logic [7:0]          irq_mask_flags_high_r;
  logic [7:0]          priority_high_bit_r;
  logic [7:0]          priority_low_bit_r;
  logic [15:0]         channel_comm_config_r [CHANNELS];
  logic [CHANNELS-1:0] enabled_r;
  logic [CHANNELS-1:0] start_pulse_r;
  logic [15:0]         rdata_r;
  logic [7:0]          pin_sync1_r;
  logic [7:0]          pin_sync2_r;

  // write decode
  wire wr_latch   = reg_wr && (reg_addr == `OFF_PORT1_LATCH);
  wire wr_dir     = reg_wr && (reg_addr == `OFF_PORT1_DIR);
  wire wr_flags   = reg_wr && (reg_addr == `OFF_IRQ_FLAGS);
  wire wr_mask    = reg_wr && (reg_addr == `OFF_IRQ_MASK);
  wire wr_start   = reg_wr && (reg_addr == `OFF_CHAN_START);
  wire wr_stop    = reg_wr && (reg_addr == `OFF_CHAN_STOP);
  wire wr_prio_hi = reg_wr && (reg_addr == `OFF_PRIO_HIGH);
  wire wr_prio_lo = reg_wr && (reg_addr == `OFF_PRIO_LOW);
  wire wr_cfg     = reg_wr && (reg_addr[3:2] == 2'b10) && (reg_addr != `OFF_CHAN_STOP);

  // hardware events land on their flag positions
  logic [7:0] event_set;
  always_comb begin
    event_set = 8'h00;
    event_set[`BIT_TX_DONE]  = tx_done_event;
    event_set[`BIT_RX_DONE]  = rx_done_event;
    event_set[`BIT_RX_ERROR] = rx_error_event;
  end

  // write one clears; a same-cycle event wins so nothing is lost
  wire [7:0] flags_nxt = (irq_request_flags_high_r & ~(wr_flags ? reg_wdata[7:0] : 8'h00))
                         | event_set;

  // only the three serial sources exist in this unit
  wire [7:0] src_mask = 8'h07;
  wire [7:0] pending  = irq_request_flags_high_r & ~irq_mask_flags_high_r & src_mask;

  // priority decode: high bit then low bit, 00 is most urgent
  function automatic prio_level_t decode_prio(input logic hi, input logic lo);
    decode_prio = prio_level_t'({hi, lo});
  endfunction

  // pick the most urgent pending source, lowest index on a tie
  prio_level_t best_level;
  logic        best_any;
  always_comb begin
    prio_level_t lv;
    lv = prio_level3;
    best_level = prio_level3;
    best_any = 1'b0;
    for (int i = 0; i < 3; i++) begin
      lv = decode_prio(priority_high_bit_r[i], priority_low_bit_r[i]);
      if (pending[i] && (!best_any || lv < best_level)) begin
        best_level = lv;
        best_any = 1'b1;
      end
    end
  end

  assign irq       = |pending;
  assign irq_level = best_level;

  // start triggers: ones set, zeros leave alone
  wire [CHANNELS-1:0] start_bits = wr_start ? reg_wdata[CHANNELS-1:0] : '0;
  wire [CHANNELS-1:0] stop_bits  = wr_stop ? reg_wdata[CHANNELS-1:0] : '0;
  wire [CHANNELS-1:0] enabled_nxt = (enabled_r & ~stop_bits) | start_bits;

  // receive enable per channel, read by the serial path
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      receive_enable_bit[c] = channel_comm_config_r[c][`BIT_RX_ENABLE];
    end
  end

  // control registers; reset chosen as masked, inputs, stopped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port1_output_latch_r     <= `RST_PORT1_LATCH;
      port1_direction_r        <= `RST_PORT1_DIR;
      irq_request_flags_high_r <= 8'h00;
      irq_mask_flags_high_r    <= `RST_IRQ_MASK;
      priority_high_bit_r      <= `RST_PRIO;
      priority_low_bit_r       <= `RST_PRIO;
      enabled_r                <= '0;
      start_pulse_r            <= '0;
    end else begin
      if (wr_latch) port1_output_latch_r <= reg_wdata[7:0];
      if (wr_dir) port1_direction_r <= reg_wdata[7:0];
      if (wr_mask) irq_mask_flags_high_r <= reg_wdata[7:0];
      if (wr_prio_hi) priority_high_bit_r <= reg_wdata[7:0];
      if (wr_prio_lo) priority_low_bit_r <= reg_wdata[7:0];
      irq_request_flags_high_r <= flags_nxt;
      enabled_r                <= enabled_nxt;
      start_pulse_r            <= start_bits;
    end
  end

  // per-channel configuration words
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        channel_comm_config_r[c] <= 16'h0000;
      end
    end else if (wr_cfg) begin
      channel_comm_config_r[reg_addr[1:0]] <= reg_wdata;
    end
  end

  assign channel_enabled_status = enabled_r;
  assign channel_start_pulse    = start_pulse_r;

  // pin inputs pass two flops before any reader
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_sync1_r <= 8'h00;
      pin_sync2_r <= 8'h00;
    end else begin
      pin_sync1_r <= port1_pin_in;
      pin_sync2_r <= pin_sync1_r;
    end
  end

  // buffer on for direction 0; rx pin normally left as input
  assign port1_pin_oe  = ~port1_direction_r;
  assign port1_pin_out = port1_output_latch_r;

  // read mux; the start register is write only and reads zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      `OFF_PORT1_LATCH:  rd_mux = {8'h00, pin_sync2_r};
      `OFF_PORT1_DIR:    rd_mux = {8'h00, port1_direction_r};
      `OFF_IRQ_FLAGS:    rd_mux = {8'h00, irq_request_flags_high_r};
      `OFF_IRQ_MASK:     rd_mux = {8'h00, irq_mask_flags_high_r};
      `OFF_CHAN_ENABLED: rd_mux = {{(16-CHANNELS){1'b0}}, enabled_r};
      `OFF_PRIO_HIGH:    rd_mux = {8'h00, priority_high_bit_r};
      `OFF_PRIO_LOW:     rd_mux = {8'h00, priority_low_bit_r};
      `OFF_IRQ_LEVEL:    rd_mux = {13'h0, best_any, best_level};
      4'hC, 4'hD, 4'hE, 4'hF: rd_mux = 16'h0000;
      4'h4, 4'h8, 4'h9, 4'hB: rd_mux = 16'h0000;
      default: rd_mux = 16'h0000;
    endcase
    if (reg_addr[3:2] == 2'b10 && reg_addr != `OFF_CHAN_STOP) begin
      rd_mux = channel_comm_config_r[reg_addr[1:0]];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_r;

endmodule
`default_nettype wire

// >>> test/uart_ctrl_sva.sv
// port checker for the serial control glue
`timescale 1ns/1ns
`default_nettype none
module uart_ctrl_sva #(
  parameter int CHANNELS = 4
) (
  input wire logic                clk_sys,
  input wire logic                srst,
  input wire logic [3:0]          reg_addr,
  input wire logic [15:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [15:0]         reg_rdata,
  input wire logic                tx_done_event,
  input wire logic                rx_done_event,
  input wire logic                rx_error_event,
  input wire logic [7:0]          port1_pin_out,
  input wire logic [7:0]          port1_pin_oe,
  input wire logic                irq,
  input wire logic [CHANNELS-1:0] channel_enabled_status,
  input wire logic [CHANNELS-1:0] channel_start_pulse
);
  logic raise_cause;
  logic clear_cause;
  logic start_wr;
  // irq may only move after an event, a flag clear or a mask write
  assign raise_cause = tx_done_event | rx_done_event | rx_error_event |
                       (reg_wr && reg_addr == 4'h3);
  assign clear_cause = reg_wr && (reg_addr == 4'h2 || reg_addr == 4'h3);
  assign start_wr    = reg_wr && reg_addr == 4'h4;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  start_sets_a: assert property (start_wr |=>
    (channel_enabled_status & $past(reg_wdata[3:0])) == $past(reg_wdata[3:0]))
    else $error("start write did not set enabled bits");
  start_pulse_a: assert property (start_wr |=> channel_start_pulse == $past(reg_wdata[3:0]))
    else $error("start pulse does not match written bits");
  no_stray_start_a: assert property (!start_wr |=>
    (channel_enabled_status & ~$past(channel_enabled_status)) == '0)
    else $error("enabled bit rose without a start write");
  dir_to_oe_a: assert property (reg_wr && reg_addr == 4'h1 |=>
    port1_pin_oe == ~$past(reg_wdata[7:0]))
    else $error("pin enable does not follow direction");
  latch_to_pin_a: assert property (reg_wr && reg_addr == 4'h0 |=>
    port1_pin_out == $past(reg_wdata[7:0]))
    else $error("pin output does not follow latch");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  irq_rise_a: assert property ($rose(irq) |-> $past(raise_cause) || $past(raise_cause, 2))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(clear_cause) || $past(clear_cause, 2))
    else $error("irq fell without clear or mask");
  cover property (irq);
  cover property (channel_start_pulse != '0);
  cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule
bind uart_channel_irq_pin_start_ctrl uart_ctrl_sva #(.CHANNELS(CHANNELS)) chk (.*);
`default_nettype wire

// >>> test/serial_peer_model.sv
// remote serial peer on the port pins
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_in
);
  logic [7:0] level;
  // undriven pins float up to the pull-up level, never a stale value
  assign level = (pin_out & pin_oe) | ~pin_oe;
  // peer echoes the tx line straight back onto the rx pin
  assign pin_in = {level[7:2], level[2], level[0]};
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// directed bench for the serial control glue
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk_sys, srst, reg_wr, reg_rd, irq;
  logic [3:0]  reg_addr, en_st, st_pulse, rx_en;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0]  ev;
  logic [7:0]  pin_in, pin_out, pin_oe;
  logic [1:0]  irq_level;
  int          err_count, total_checks;
  uart_channel_irq_pin_start_ctrl dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_done_event(ev[0]), .rx_done_event(ev[1]), .rx_error_event(ev[2]),
    .port1_pin_in(pin_in), .port1_pin_out(pin_out), .port1_pin_oe(pin_oe), .irq(irq),
    .irq_level(irq_level), .channel_enabled_status(en_st), .channel_start_pulse(st_pulse),
    .receive_enable_bit(rx_en));
  serial_peer_model peer (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  // 4 ns system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev <= 3'h0;
  endtask
  // one settling edge so a registered irq would also be seen
  task automatic irq_is(input logic exp);
    @(posedge clk_sys);
    #1 chk({15'h0, irq}, {15'h0, exp});
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
  // main sequence
  initial begin
    {srst, reg_wr, reg_rd, ev, reg_addr, reg_wdata} = {1'b1, 25'h0};
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(4'h1, 16'h00FF);
    rd(4'h3, 16'h00FF);
    rd(4'h2, 16'h0000);
    rd(4'hE, 16'h0000);
    wr(4'h1, 16'h00FB);
    wr(4'h0, 16'h0004);
    #1 chk({8'h0, pin_oe}, 16'h0004);
    chk({8'h0, pin_out}, 16'h0004);
    repeat (3) @(posedge clk_sys);
    rd(4'h0, 16'h00FF);
    wr(4'h0, 16'h0000);
    repeat (3) @(posedge clk_sys);
    rd(4'h0, 16'h00F9);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      rd(4'h2, 16'h0001 << i);
      irq_is(1'b0);
      wr(4'h2, 16'h0001 << i);
      rd(4'h2, 16'h0000);
    end
    wr(4'h3, 16'h0000);
    irq_is(1'b0);
    pulse(0);
    irq_is(1'b1);
    wr(4'h3, 16'h0001);
    irq_is(1'b0);
    wr(4'h3, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(4'h6, {15'h0, c[1]});
      wr(4'h7, {15'h0, c[0]});
      @(posedge clk_sys);
      #1 chk({14'h0, irq_level}, c[15:0]);
    end
    wr(4'h2, 16'h0001);
    irq_is(1'b0);
    wr(4'h9, 16'h4000);
    #1 chk({12'h0, rx_en}, 16'h0002);
    repeat (4) @(posedge clk_sys);
    wr(4'h4, 16'h0002);
    #1 chk({12'h0, en_st}, 16'h0002);
    chk({12'h0, st_pulse}, 16'h0002);
    wr(4'h4, 16'h0000);
    #1 chk({12'h0, en_st}, 16'h0002);
    chk({12'h0, st_pulse}, 16'h0000);
    wr(4'h4, 16'h000D);
    rd(4'h5, 16'h000F);
    // stop clears only the written ones
    wr(4'h8, 16'h0005);
    rd(4'h5, 16'h000A);
    // event and clear in one cycle: the event must win
    @(posedge clk_sys);
    ev[2]     <= 1'b1;
    reg_wr    <= 1'b1;
    reg_addr  <= 4'h2;
    reg_wdata <= 16'h0004;
    @(posedge clk_sys);
    ev     <= 3'h0;
    reg_wr <= 1'b0;
    rd(4'h2, 16'h0004);
    wr(4'h2, 16'h0004);
    rd(4'h2, 16'h0000);
    give_verdict;
  end
endmodule
`default_nettype wire
